// File: core/ipf_pin_mux.sv
`timescale 1ns/10ps
`include "ipf_defs.svh"

// Contract
// - Drive memory write; input under external master
// - I/O 16-bit select makes 16-bit I/O
// - Memory 16-bit select makes 16-bit memory
// - Master input turns address, commands to input
// - Cycle not ended until channel ready high
// - Drive buffered address latch enable
// - IDE cycle puts first drive select on bit3
// - IDE cycle puts second drive select on bit4
// - Line eight/seven straps pick shared pin role
// - Terminal count pin: count on DMA, else fast-bus
// - Line six low: read strobe, else parity two
// - Line six low: write strobe, else parity three
module ipf_pin_mux (
    input wire logic core_clk,
    input wire logic rst_n,
    // Internal cycle request side
    input wire logic cyc_req,
    input wire logic cyc_mem,
    input wire logic cyc_write,
    input wire logic cyc_dma,
    input wire logic cyc_ide,
    input wire logic [1:0] cyc_ide_cs,
    input wire logic [7:0] cyc_addr,
    input wire logic cyc_bhe,
    input wire logic dma_tc,
    input wire logic fast_bus_act,
    input wire logic lgnt2_grant,
    input wire logic hbank_sel,
    input wire logic [1:0] par_out,
    input wire logic [1:0] par_drive,
    output logic cyc_busy_ff,
    output logic cyc_done_ff,
    output logic cyc_wide_ff,
    output logic ext_master_ff,
    output logic [3:0] ext_cmd_ff,
    output logic [7:0] ext_addr_ff,
    output logic ext_bhe_ff,
    output logic [1:0] par_in_ff,
    output logic ide_mode_ff,
    output ipf_pkg::ipf_role_t role_ff,
    // ISA pins
    output logic [7:0] sa_o_ff,
    output logic sa_oe_ff,
    input wire logic [7:0] sa_i,
    output logic sbhe_n_o_ff,
    output logic sbhe_n_oe_ff,
    input wire logic sbhe_n_i,
    output logic [3:0] cmd_n_o_ff,
    output logic cmd_n_oe_ff,
    input wire logic [3:0] cmd_n_i,
    output logic bale_ff,
    input wire logic io16_n,
    input wire logic ms16_n,
    input wire logic master_n,
    input wire logic iochrdy,
    output logic tc_o_ff,
    // Shared grant / bank / fast-bus pin
    output logic shr_pin_o_ff,
    output logic shr_pin_oe_ff,
    input wire logic shr_pin_i,
    // Shared IDE strobe / parity pins
    output logic [1:0] strb_pin_o_ff,
    output logic [1:0] strb_pin_oe_ff,
    input wire logic [1:0] strb_pin_i,
    // Reset-time straps on DRAM address lines
    input wire logic dram_address_line_six_strap,
    input wire logic dram_address_line_seven_strap,
    input wire logic dram_address_line_eight_strap
);
    import ipf_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // All pins but the unused shared pin input cross two flops before any logic sees them
    logic [`IPF_S_W-1:0] raw_in;
    logic [`IPF_S_W-1:0] syn;
    assign raw_in = {sa_i, strb_pin_i, cmd_n_i, sbhe_n_i,
                     dram_address_line_eight_strap,
                     dram_address_line_seven_strap,
                     dram_address_line_six_strap,
                     iochrdy, master_n, ms16_n, io16_n};

    // Runs without reset so straps are settled when reset lifts
    ipf_sync #(.W(`IPF_S_W)) u_sync (
        .core_clk(core_clk),
        .async_in(raw_in),
        .sync_out(syn)
    );

    // Pin reads named by meaning, all active high
    wire io_wide = ~syn[`IPF_S_IO16];
    wire mem_wide = ~syn[`IPF_S_MS16];
    wire master_on = ~syn[`IPF_S_MASTER];
    wire chan_ready = syn[`IPF_S_RDY];
    // Unused shared pin input is tied off by design intent
    wire shr_unused = shr_pin_i;

    // ==========================================================
    // Strap capture
    // ==========================================================
    logic strap_taken_ff; // Straps already latched since reset
    logic nxt_ide_mode;
    ipf_role_t nxt_role;

    // Line eight high wins; otherwise line seven picks grant or bank
    assign nxt_role = syn[`IPF_S_A8] ? IPF_ROLE_FAST_BUS :
                      (syn[`IPF_S_A7] ? IPF_ROLE_HBANK : IPF_ROLE_LGNT2);
    assign nxt_ide_mode = ~syn[`IPF_S_A6];

    // Caught on the first edge after release, once only; the
    // synchroniser has refilled by then since it runs in reset too
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_taken_ff <= 1'b0;
            ide_mode_ff <= 1'b1;
            role_ff <= IPF_ROLE_FAST_BUS;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            ide_mode_ff <= nxt_ide_mode;
            role_ff <= nxt_role;
        end
    end

    // ==========================================================
    // Cycle sequencer
    // ==========================================================
    ipf_state_t state_ff;
    ipf_state_t nxt_state;
    logic [`IPF_CNT_W-1:0] cnt_ff; // Command width counter
    logic [`IPF_CNT_W-1:0] nxt_cnt;
    logic c_mem_ff; // Latched cycle attributes
    logic c_write_ff;
    logic c_dma_ff;
    logic c_ide_ff;
    logic [1:0] c_cs_ff;
    logic [7:0] c_addr_ff;
    logic c_bhe_ff;

    // Requests are refused while an outside master owns the bus
    wire take = cyc_req && !master_on && strap_taken_ff;
    wire cnt_done = (cnt_ff == `IPF_CNT_W'(`IPF_CMD_CYC - 1));

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            IPF_IDLE: begin
                // Start with the latch pulse
                if (take) begin
                    nxt_state = IPF_ALE;
                end
            end
            IPF_ALE: begin
                nxt_state = IPF_CMD;
                nxt_cnt = '0;
            end
            IPF_CMD: begin
                // Hold the least command width first
                nxt_cnt = cnt_ff + `IPF_CNT_W'(1);
                if (cnt_done) begin
                    nxt_state = IPF_WAIT;
                end
            end
            IPF_WAIT: begin
                // Target stretches the cycle by pulling ready low
                if (chan_ready) begin
                    nxt_state = IPF_END;
                end
            end
            IPF_END: begin
                nxt_state = IPF_IDLE;
            end
            default: begin
                nxt_state = IPF_IDLE;
            end
        endcase
    end

    // State and counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= IPF_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Attributes held for the whole cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {c_mem_ff, c_write_ff, c_dma_ff, c_ide_ff} <= 4'h0;
            c_cs_ff <= 2'h0;
            c_addr_ff <= 8'h00;
            c_bhe_ff <= 1'b0;
        end else if (state_ff == IPF_IDLE && take) begin
            {c_mem_ff, c_write_ff, c_dma_ff, c_ide_ff} <=
                {cyc_mem, cyc_write, cyc_dma, cyc_ide};
            c_cs_ff <= cyc_ide_cs;
            c_addr_ff <= cyc_addr;
            c_bhe_ff <= cyc_bhe;
        end
    end

    // ==========================================================
    // Next pin values
    // ==========================================================
    wire in_cyc = (state_ff != IPF_IDLE);
    wire cmd_on = (state_ff == IPF_CMD) || (state_ff == IPF_WAIT);
    // IDE cycles in IDE strap mode use the dedicated strobes
    wire ide_strobe = c_ide_ff && ide_mode_ff;
    wire [1:0] cmd_idx = {~c_mem_ff, c_write_ff};
    wire drive_bus = !master_on;

    // Address with drive selects muxed onto bits 3 and 4
    logic [7:0] nxt_sa;
    assign nxt_sa = {c_addr_ff[7:5],
                     c_ide_ff ? ~c_cs_ff[1] : c_addr_ff[4],
                     c_ide_ff ? ~c_cs_ff[0] : c_addr_ff[3],
                     c_addr_ff[2:0]};

    // One-hot active-low command, slot picked by cycle type
    logic [3:0] nxt_cmd_n;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_cmd
            assign nxt_cmd_n[k] = ~(cmd_on && !ide_strobe && cmd_idx == 2'(k));
        end
    endgenerate

    // Wide when the addressed target claims 16-bit for this type
    wire nxt_wide = c_mem_ff ? mem_wide : io_wide;

    // Shared grant / bank / fast-bus value, all active low
    logic nxt_shr;
    assign nxt_shr = (role_ff == IPF_ROLE_LGNT2) ? ~lgnt2_grant :
                     (role_ff == IPF_ROLE_HBANK) ? ~hbank_sel :
                     ~fast_bus_act;

    // Terminal count on DMA cycles, fast-bus indication otherwise
    wire nxt_tc = (in_cyc && c_dma_ff) ? dma_tc : ~fast_bus_act;

    // IDE strobes or parity on the two shared DRAM pins
    logic [1:0] nxt_strb;
    logic [1:0] nxt_strb_oe;
    assign nxt_strb[0] = ide_mode_ff ? ~(cmd_on && ide_strobe && !c_write_ff) : par_out[0];
    assign nxt_strb[1] = ide_mode_ff ? ~(cmd_on && ide_strobe && c_write_ff) : par_out[1];
    assign nxt_strb_oe = ide_mode_ff ? 2'h3 : par_drive;

    // ==========================================================
    // Pin and status registers
    // ==========================================================
    // ISA address, byte enable and command pins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sa_o_ff <= 8'h00;
            sa_oe_ff <= 1'b0;
            sbhe_n_o_ff <= 1'b1;
            sbhe_n_oe_ff <= 1'b0;
            cmd_n_o_ff <= 4'hF;
            cmd_n_oe_ff <= 1'b0;
            bale_ff <= 1'b0;
        end else begin
            sa_o_ff <= nxt_sa;
            sa_oe_ff <= drive_bus;
            sbhe_n_o_ff <= ~c_bhe_ff;
            sbhe_n_oe_ff <= drive_bus;
            cmd_n_o_ff <= nxt_cmd_n;
            cmd_n_oe_ff <= drive_bus;
            // Latch pulse rises with the address in the same cycle, so cards
            // latch on its fall while the address is already stable
            bale_ff <= (state_ff == IPF_ALE);
        end
    end

    // Shared pins; oe held low until the straps are known
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tc_o_ff <= 1'b1;
            shr_pin_o_ff <= 1'b1;
            shr_pin_oe_ff <= 1'b0;
            strb_pin_o_ff <= 2'h3;
            strb_pin_oe_ff <= 2'h0;
        end else begin
            tc_o_ff <= nxt_tc;
            shr_pin_o_ff <= nxt_shr;
            shr_pin_oe_ff <= strap_taken_ff;
            strb_pin_o_ff <= nxt_strb;
            strb_pin_oe_ff <= strap_taken_ff ? nxt_strb_oe : 2'h0;
        end
    end

    // Status back to the cycle logic
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cyc_busy_ff <= 1'b0;
            cyc_done_ff <= 1'b0;
            cyc_wide_ff <= 1'b0;
            ext_master_ff <= 1'b0;
            ext_cmd_ff <= 4'h0;
            ext_addr_ff <= 8'h00;
            ext_bhe_ff <= 1'b0;
            par_in_ff <= 2'h0;
        end else begin
            cyc_busy_ff <= (nxt_state != IPF_IDLE);
            cyc_done_ff <= (state_ff == IPF_WAIT) && chan_ready;
            // Width is sampled at latch time and held
            if (state_ff == IPF_ALE) begin
                cyc_wide_ff <= nxt_wide;
            end
            ext_master_ff <= master_on;
            // Master commands seen only while we are not driving
            ext_cmd_ff <= master_on ? ~syn[`IPF_S_CMD +: 4] : 4'h0;
            ext_addr_ff <= syn[`IPF_S_SA +: 8];
            ext_bhe_ff <= ~syn[`IPF_S_SBHE];
            par_in_ff <= ide_mode_ff ? 2'h0 : (syn[`IPF_S_PAR +: 2] | {2{shr_unused & 1'b0}});
        end
    end
endmodule

// File: core/ipf_sync.sv
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser, one pair of flops per bit
// ==========================================================
module ipf_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // First stage is read only by the second stage
            logic meta_ff;
            logic stab_ff;
            // No reset: pins keep flowing through reset, so the straps
            // are already settled at the first edge after release
            always_ff @(posedge core_clk) begin
                meta_ff <= async_in[g];
                stab_ff <= meta_ff;
            end
            assign sync_out[g] = stab_ff;
        end
    endgenerate
endmodule

// File: dv/ipf_isa_card.sv
`timescale 1ns/10ps
// ==========================================================
// ISA card model: width selects, wait states, bus master
// ==========================================================
module ipf_isa_card (
    input wire logic core_clk,
    input wire logic [3:0] cmd_n,
    input wire logic sel_io,
    input wire logic sel_ms,
    input wire logic [1:0] wait_n,
    input wire logic own_bus,
    input wire logic [3:0] own_cmd,
    output logic io16_n,
    output logic ms16_n,
    output logic iochrdy,
    output logic master_n,
    output logic [3:0] card_cmd_n,
    output logic card_oe
);
    int cnt = 0; // Cycles the command has been active
    // Selects answer at once; a real card would decode first
    assign io16_n = !sel_io;
    assign ms16_n = !sel_ms;
    assign master_n = !own_bus;
    assign card_oe = own_bus;
    // Released command lines fall back to the bus pull-up
    assign card_cmd_n = own_bus ? ~own_cmd : 4'hF;
    // Ready held low for three cycles per wait step
    assign iochrdy = (cmd_n == 4'hF) || (cnt >= 3 * wait_n);
    // Count only while some command is active
    always @(posedge core_clk) begin
        cnt <= (cmd_n == 4'hF) ? 0 : cnt + 1;
    end
endmodule

// File: dv/ipf_pin_mux_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Pin-function checker on the top-level ports
// ==========================================================
module ipf_pin_mux_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cyc_mem,
    input wire logic cyc_write,
    input wire logic cyc_dma,
    input wire logic cyc_ide,
    input wire logic [1:0] cyc_ide_cs,
    input wire logic [7:0] cyc_addr,
    input wire logic fast_bus_act,
    input wire logic dma_tc,
    input wire logic [1:0] par_out,
    input wire logic [1:0] par_drive,
    input wire logic cyc_bhe,
    input wire logic lgnt2_grant,
    input wire logic hbank_sel,
    input wire logic cyc_busy_ff,
    input wire logic cyc_done_ff,
    input wire logic ide_mode_ff,
    input wire ipf_pkg::ipf_role_t role_ff,
    input wire logic [7:0] sa_o_ff,
    input wire logic sa_oe_ff,
    input wire logic [3:0] cmd_n_o_ff,
    input wire logic cmd_n_oe_ff,
    input wire logic bale_ff,
    input wire logic master_n,
    input wire logic iochrdy,
    input wire logic tc_o_ff,
    input wire logic [1:0] strb_pin_o_ff,
    input wire logic [1:0] strb_pin_oe_ff,
    input wire logic sbhe_n_o_ff,
    input wire logic sbhe_n_oe_ff,
    input wire logic shr_pin_o_ff,
    input wire logic shr_pin_oe_ff,
    input wire logic [1:0] par_in_ff,
    input wire logic [1:0] strb_pin_i
);
    import ipf_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ======================================================
    // Sequences
    // ======================================================
    // Latch enable is a single-cycle pulse
    sequence s_ale;
        bale_ff ##1 !bale_ff;
    endsequence
    // Memory write strobe held for the least command width
    sequence s_memw;
        (!cmd_n_o_ff[1] && cmd_n_oe_ff) [*3];
    endsequence
    // ======================================================
    // Properties
    // ======================================================
    property p_bale;
        $rose(bale_ff) |-> s_ale;
    endproperty
    a_bale: assert property (p_bale) else $error("latch enable not one cycle");
    property p_sa;
        bale_ff && !cyc_ide |-> sa_oe_ff && sa_o_ff == cyc_addr && sbhe_n_o_ff == !cyc_bhe;
    endproperty
    a_sa: assert property (p_sa) else $error("address not driven at latch");
    property p_memw;
        bale_ff && cyc_mem && cyc_write && !cyc_ide |=> s_memw;
    endproperty
    a_memw: assert property (p_memw) else $error("memory write not driven");
    property p_ide;
        bale_ff && cyc_ide |-> sa_o_ff[3] == !cyc_ide_cs[0] && sa_o_ff[4] == !cyc_ide_cs[1];
    endproperty
    a_ide: assert property (p_ide) else $error("drive selects wrong on address");
    property p_rdy;
        !iochrdy [*5] |-> !cyc_done_ff;
    endproperty
    a_rdy: assert property (p_rdy) else $error("cycle ended while not ready");
    property p_early;
        $rose(cyc_busy_ff) |-> !cyc_done_ff [*4];
    endproperty
    a_early: assert property (p_early) else $error("cycle ended too early");
    property p_master;
        !master_n [*4] |-> !cmd_n_oe_ff && !sa_oe_ff && !sbhe_n_oe_ff;
    endproperty
    a_master: assert property (p_master) else $error("pins driven under master");
    property p_tc;
        $past(rst_n) && !cyc_busy_ff && !$past(cyc_busy_ff) && $stable(fast_bus_act) |-> tc_o_ff == !fast_bus_act;
    endproperty
    a_tc: assert property (p_tc) else $error("count pin not fast-bus outside DMA");
    property p_tc_dma;
        $past(cyc_busy_ff) && cyc_busy_ff && cyc_dma && $stable(dma_tc) |-> tc_o_ff == dma_tc;
    endproperty
    a_tc_dma: assert property (p_tc_dma) else $error("count pin wrong in DMA");
    property p_strap;
        $past(rst_n, 2) |-> $stable(ide_mode_ff) && $stable(role_ff);
    endproperty
    a_strap: assert property (p_strap) else $error("pin role changed after reset");
    property p_par;
        $past(rst_n, 2) && !ide_mode_ff && $stable(par_out) && $stable(par_drive)
            |=> strb_pin_o_ff == $past(par_out) && strb_pin_oe_ff == $past(par_drive);
    endproperty
    a_par: assert property (p_par) else $error("parity pins wrong");
    // Shared pin carries the strapped role's level, inverted
    property p_shr;
        $past(rst_n, 2) |=> shr_pin_oe_ff && shr_pin_o_ff == !$past(role_ff == IPF_ROLE_LGNT2 ? lgnt2_grant :
            (role_ff == IPF_ROLE_HBANK ? hbank_sel : fast_bus_act));
    endproperty
    a_shr: assert property (p_shr) else $error("shared role pin wrong");
    // Parity pins read back through the synchroniser in parity mode only
    property p_parin;
        $past(rst_n, 3) |-> par_in_ff == (ide_mode_ff ? 2'h0 : $past(strb_pin_i, 3));
    endproperty
    a_parin: assert property (p_parin) else $error("parity input wrong");
endmodule

// File: dv/isa_ide_pin_function_select_tb.sv
`timescale 1ns/10ps
// ==========================================================
// Pin-function testbench
// ==========================================================
module isa_ide_pin_function_select_tb;
    import ipf_pkg::*;
    logic core_clk = 0, rst_n = 0, cyc_req = 0, cyc_mem = 0, cyc_write = 0, cyc_dma = 0, cyc_ide = 0;
    logic [1:0] cyc_ide_cs = 0, par_out = 0, par_drive = 0, ext_par = 0, wait_n = 0;
    logic [7:0] cyc_addr = 0;
    logic cyc_bhe = 0, dma_tc = 0, fast_bus_act = 0, lgnt2_grant = 0, hbank_sel = 0;
    logic a6 = 0, a7 = 0, a8 = 0, sel_io = 0, sel_ms = 0, own_bus = 0, card_oe;
    logic [3:0] own_cmd = 0, card_cmd_n, cmd_n_o_ff, ext_cmd_ff;
    logic cyc_busy_ff, cyc_done_ff, cyc_wide_ff, ext_master_ff, ide_mode_ff, sa_oe_ff, cmd_n_oe_ff;
    logic sbhe_n_o_ff, sbhe_n_oe_ff, bale_ff, io16_n, ms16_n, master_n, iochrdy, tc_o_ff, ext_bhe_ff;
    logic [7:0] sa_o_ff, ext_addr_ff, own_addr = 0;
    logic [1:0] strb_pin_o_ff, strb_pin_oe_ff, seen_strb;
    ipf_role_t role_ff;
    int errors = 0, tests_run = 0, cycles = 0;
    // Wire levels; the master drives the address and commands, released strobe lines take ext_par, the other released lines sit at their pull-up
    wire [3:0] cmd_w = cmd_n_oe_ff ? cmd_n_o_ff : card_cmd_n;
    wire [7:0] sa_w = sa_oe_ff ? sa_o_ff : own_addr;
    wire sbhe_w = sbhe_n_oe_ff ? sbhe_n_o_ff : 1'b1;
    wire [1:0] strb_w = (strb_pin_oe_ff & strb_pin_o_ff) | (~strb_pin_oe_ff & ext_par);
    ipf_pin_mux i_dut (.core_clk, .rst_n, .cyc_req, .cyc_mem, .cyc_write, .cyc_dma, .cyc_ide, .cyc_ide_cs,
        .cyc_addr, .cyc_bhe, .dma_tc, .fast_bus_act, .lgnt2_grant, .hbank_sel, .par_out, .par_drive,
        .cyc_busy_ff, .cyc_done_ff, .cyc_wide_ff, .ext_master_ff, .ext_cmd_ff, .ext_addr_ff, .ext_bhe_ff,
        .par_in_ff(), .ide_mode_ff, .role_ff, .sa_o_ff, .sa_oe_ff, .sa_i(sa_w), .sbhe_n_o_ff, .sbhe_n_oe_ff,
        .sbhe_n_i(sbhe_w), .cmd_n_o_ff, .cmd_n_oe_ff, .cmd_n_i(cmd_w), .bale_ff, .io16_n, .ms16_n, .master_n,
        .iochrdy, .tc_o_ff, .shr_pin_o_ff(), .shr_pin_oe_ff(), .shr_pin_i(1'b1), .strb_pin_o_ff,
        .strb_pin_oe_ff, .strb_pin_i(strb_w), .dram_address_line_six_strap(a6),
        .dram_address_line_seven_strap(a7), .dram_address_line_eight_strap(a8));
    ipf_isa_card i_card (.core_clk, .cmd_n(cmd_w), .sel_io, .sel_ms, .wait_n, .own_bus, .own_cmd, .io16_n,
        .ms16_n, .iochrdy, .master_n, .card_cmd_n, .card_oe);
    // ======================================================
    // Clock, background noise and hang guard
    // ======================================================
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // Side inputs change every cycle so the selectors see both values
    always @(negedge core_clk) begin
        {dma_tc, fast_bus_act, lgnt2_grant, hbank_sel, par_out, par_drive, ext_par} <= 10'($urandom);
    end
    // Under a thousand cycles are expected; far beyond means a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    // ======================================================
    // Tasks
    // ======================================================
    task automatic chk(string n, int exp, logic [7:0] got);
        tests_run++;
        if (got !== 8'(exp)) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One internal cycle of kind k with random width answer and waits
    task automatic run_cycle(int k, bit ide_on);
        logic [3:0] seen_cmd;
        seen_cmd = 0;
        seen_strb = 0;
        {sel_io, sel_ms, wait_n, cyc_addr, cyc_ide_cs, cyc_bhe, cyc_dma} = 16'($urandom);
        {cyc_mem, cyc_write} = {!k[1], k[0]};
        cyc_ide = k[1] && ($urandom % 2);
        // Width selects must cross the pin synchroniser before the latch state
        repeat (2) @(negedge core_clk);
        cyc_req = 1;
        for (int i = 0; i < 10 && !cyc_busy_ff; i++) @(negedge core_clk);
        cyc_req = 0;
        for (int i = 0; i < 200 && !cyc_done_ff; i++) begin
            @(negedge core_clk);
            seen_cmd |= ~cmd_n_o_ff & {4{cmd_n_oe_ff}};
            seen_strb |= ~strb_pin_o_ff & strb_pin_oe_ff;
        end
        chk("done", 1, cyc_done_ff);
        chk("wide", cyc_mem ? sel_ms : sel_io, cyc_wide_ff);
        chk("isa command", (cyc_ide && ide_on) ? 0 : 1 << k, seen_cmd);
        if (ide_on) chk("ide strobe", cyc_ide ? (k[0] ? 2 : 1) : 0, seen_strb);
        @(negedge core_clk);
    endtask
    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        logic [2:0] straps [4] = '{3'b100, 3'b001, 3'b010, 3'b111};
        void'($urandom(32'hA6EE));
        foreach (straps[p]) begin
            @(negedge core_clk);
            {a8, a7, a6} = straps[p];
            rst_n = 0;
            repeat (8) @(negedge core_clk);
            rst_n = 1;
            repeat (3) @(negedge core_clk);
            {a8, a7, a6} = ~straps[p];
            repeat (3) @(negedge core_clk);
            chk("role", straps[p][2] ? 0 : (straps[p][1] ? 2 : 1), role_ff);
            chk("ide mode", !straps[p][0], ide_mode_ff);
            for (int n = 0; n < 12; n++) run_cycle(n % 4, !straps[p][0]);
            own_cmd = 4'h1 << (p % 4);
            own_addr = 8'($urandom);
            own_bus = 1;
            // Ask only once the master indication has crossed the synchroniser
            repeat (3) @(negedge core_clk);
            cyc_req = 1;
            repeat (6) @(negedge core_clk);
            chk("master address", own_addr, ext_addr_ff);
            chk("master byte high", 0, ext_bhe_ff);
            chk("command drive", 0, cmd_n_oe_ff);
            chk("master", 1, ext_master_ff);
            chk("master command", own_cmd, ext_cmd_ff);
            chk("busy", 0, cyc_busy_ff);
            own_bus = 0;
            cyc_req = 0;
            repeat (6) @(negedge core_clk);
        end
        summarize();
    end
endmodule

bind ipf_pin_mux ipf_pin_mux_sva i_sva (.core_clk, .rst_n, .cyc_mem, .cyc_write, .cyc_dma, .cyc_ide,
    .cyc_ide_cs, .cyc_addr, .fast_bus_act, .dma_tc, .par_out, .par_drive, .cyc_busy_ff, .cyc_done_ff,
    .ide_mode_ff, .role_ff, .sa_o_ff, .sa_oe_ff, .cmd_n_o_ff, .cmd_n_oe_ff, .bale_ff, .master_n, .iochrdy,
    .tc_o_ff, .strb_pin_o_ff, .strb_pin_oe_ff, .cyc_bhe, .lgnt2_grant, .hbank_sel, .sbhe_n_o_ff, .sbhe_n_oe_ff,
    .shr_pin_o_ff, .shr_pin_oe_ff, .par_in_ff, .strb_pin_i);

// File: shared/ipf_defs.svh
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH

// ==========================================================
// Clock and command timing
// ==========================================================
// Core clock rate in MHz
`define IPF_CLK_MHZ 10
// Least command strobe width in ns
`define IPF_CMD_NS 300
// Least command width in cycles, rounded up
`define IPF_CMD_CYC ((`IPF_CMD_NS * `IPF_CLK_MHZ + 999) / 1000)
// Width of the command counter
`define IPF_CNT_W 4

// ==========================================================
// Command slot indices (index = {io, write})
// ==========================================================
`define IPF_CMD_MEMR 0
`define IPF_CMD_MEMW 1
`define IPF_CMD_IOR 2
`define IPF_CMD_IOW 3

// ==========================================================
// Synchroniser vector layout
// ==========================================================
`define IPF_S_IO16 0
`define IPF_S_MS16 1
`define IPF_S_MASTER 2
`define IPF_S_RDY 3
`define IPF_S_A6 4
`define IPF_S_A7 5
`define IPF_S_A8 6
`define IPF_S_SBHE 7
`define IPF_S_CMD 8
`define IPF_S_PAR 12
`define IPF_S_SA 14
`define IPF_S_W 22

`endif

// File: shared/ipf_pkg.sv
// ==========================================================
// Types shared by the pin-function block
// ==========================================================
package ipf_pkg;
    // Role of the shared grant / bank / fast-bus pin
    typedef enum logic [1:0] {
        IPF_ROLE_FAST_BUS,
        IPF_ROLE_LGNT2,
        IPF_ROLE_HBANK
    } ipf_role_t;

    // ISA cycle sequencer states
    typedef enum logic [2:0] {
        IPF_IDLE,
        IPF_ALE,
        IPF_CMD,
        IPF_WAIT,
        IPF_END
    } ipf_state_t;
endpackage
